//--- cpu_timer_access.sv
// Package of shared constants for the three countdown timers, and the
// access decoder that splits a 16- or 32-bit CPU memory access into words.
// Assumes a single clock domain and a frame select already decoded by the CPU.
`timescale 1ns/1ps
`default_nettype none

package cpu_timer_pkg;
   // Frame geometry, in 16-bit words
   localparam int          FRAME_WORDS  = 64;
   localparam int          ADDR_W       = 6;
   localparam int          TIMER_COUNT  = 3;
   localparam logic [5:0]  TIMER_STRIDE = 6'h08;
   // Word offsets inside one timer slot
   localparam logic [2:0]  OFS_CNT_LO   = 3'h0;
   localparam logic [2:0]  OFS_CNT_HI   = 3'h1;
   localparam logic [2:0]  OFS_PRD_LO   = 3'h2;
   localparam logic [2:0]  OFS_PRD_HI   = 3'h3;
   localparam logic [2:0]  OFS_CTL      = 3'h4;
   localparam logic [2:0]  OFS_PSC      = 3'h6;
   // Control word fields
   localparam int          CTL_STOP_BIT   = 0;
   localparam int          CTL_RELOAD_BIT = 1;
   // Reset values
   localparam logic [31:0] RST_COUNT    = 32'hFFFF_FFFF;
   localparam logic [31:0] RST_PERIOD   = 32'hFFFF_FFFF;
   localparam logic [15:0] RST_PSC      = 16'h0001;
   localparam logic        RST_STOP     = 1'b0;

   // Per-timer state
   typedef struct packed {
      logic [31:0] count;    // Down counter
      logic [31:0] period;   // Reload value
      logic [15:0] psc_set;  // Programmed prescale divisor
      logic [15:0] psc_cnt;  // Prescaler down count
      logic        stop;     // Counting halted
      logic        irq;      // Zero-arrival pulse
   } timer_state_t;
endpackage

////////////////////////////////////////////////////////////////////////////////

module cpu_timer_access (
   input  wire logic       i_sel,       // Access targets the timer frame
   input  wire logic       i_wr,        // Write strobe
   input  wire logic       i_wide,      // 32-bit access when high
   input  wire logic [5:0] i_addr,      // Word address within frame
   output logic            o_wen_lo,    // Write to word o_addr_lo
   output logic            o_wen_hi,    // Write to word o_addr_hi
   output logic [5:0]      o_addr_lo,   // Low word address
   output logic [5:0]      o_addr_hi    // High word address (wide only)
);
   // A wide access is forced to an even pair so its halves never straddle
   always_comb begin
      o_addr_lo = i_wide ? {i_addr[5:1], 1'b0} : i_addr;
      o_addr_hi = {i_addr[5:1], 1'b1};
      o_wen_lo  = i_sel && i_wr;
      o_wen_hi  = i_sel && i_wr && i_wide;
   end
endmodule

`default_nettype wire

//--- cpu_countdown_timers.sv
// Three identical 32-bit countdown timers with 16-bit prescalers, reached
// over the CPU memory bus in a 64-word frame, with their interrupt routing.
// Assumes all inputs synchronous to i_mclk; the bus holds no wait states.
`timescale 1ns/1ps
`default_nettype none

module cpu_countdown_timers (
   input  wire logic        i_mclk,                  // 200 MHz CPU clock
   input  wire logic        i_rst,                   // Synchronous reset, high
   input  wire logic        i_mem_sel,               // Frame selected
   input  wire logic        i_mem_rd,                // Read strobe
   input  wire logic        i_mem_wr,                // Write strobe
   input  wire logic        i_mem_wide,              // 32-bit access
   input  wire logic [5:0]  i_mem_addr,              // Word address in frame
   input  wire logic [31:0] i_mem_wdata,             // Write data
   input  wire logic        i_line13_route_en,       // Connect timer 1 to line 13
   input  wire logic        i_line13_other_src,      // Other source on line 13
   output logic [31:0]      o_mem_rdata,             // Read data, registered
   output logic             o_mem_rvalid,            // Read data valid pulse
   output logic             o_expander_timer0_irq,   // To interrupt expander
   output logic             o_cpu_irq_line_thirteen, // CPU line thirteen
   output logic             o_cpu_irq_line_fourteen  // CPU line fourteen
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      cpu_timer_pkg::timer_state_t [2:0] tmr;    // The three timers
      logic [31:0]                       rdata;  // Read data holding register
      logic                              rvalid; // Read answer pulse
   } state_t;

   state_t      state_reg;                      // Registered state
   state_t      state_next;                     // Next state
   logic        wen_lo;                         // Low word write
   logic        wen_hi;                         // High word write
   logic [5:0]  addr_lo;                        // Low word address
   logic [5:0]  addr_hi;                        // High word address
   logic [2:0]  tick;                           // Prescale interval elapsed
   logic [2:0]  sw_touch;                       // Software wrote this timer

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Effective divisor minus one; a zero setting divides by one
   function automatic logic [15:0] psc_start(input logic [15:0] set);
      psc_start = (set == 16'h0000) ? 16'h0000 : set - 16'h0001;
   endfunction

   // Write enable and data for one frame word, from either bus half
   function automatic logic [16:0] word_wr(input logic [5:0] idx,
                                           input logic en_a, input logic [5:0] ad_a,
                                           input logic en_b, input logic [5:0] ad_b,
                                           input logic [31:0] wd);
      if (en_a && ad_a == idx) begin
         word_wr = {1'b1, wd[15:0]};
      end else if (en_b && ad_b == idx) begin
         word_wr = {1'b1, wd[31:16]};
      end else begin
         word_wr = 17'h0_0000;
      end
   endfunction

   // Read view of one frame word; unmapped words read as zero
   function automatic logic [15:0] rd_word(input cpu_timer_pkg::timer_state_t [2:0] t,
                                           input logic [5:0] idx);
      logic [1:0] n;
      n = idx[4:3];
      rd_word = 16'h0000;
      if (idx[5] == 1'b0 && n != 2'h3) begin
         case (idx[2:0])
            cpu_timer_pkg::OFS_CNT_LO: rd_word = t[n].count[15:0];
            cpu_timer_pkg::OFS_CNT_HI: rd_word = t[n].count[31:16];
            cpu_timer_pkg::OFS_PRD_LO: rd_word = t[n].period[15:0];
            cpu_timer_pkg::OFS_PRD_HI: rd_word = t[n].period[31:16];
            cpu_timer_pkg::OFS_CTL:    rd_word = {15'h0000, t[n].stop};
            cpu_timer_pkg::OFS_PSC:    rd_word = t[n].psc_set;
            default:                   rd_word = 16'h0000;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Bus access split

   cpu_timer_access u_access (
      .i_sel     (i_mem_sel),
      .i_wr      (i_mem_wr),
      .i_wide    (i_mem_wide),
      .i_addr    (i_mem_addr),
      .o_wen_lo  (wen_lo),
      .o_wen_hi  (wen_hi),
      .o_addr_lo (addr_lo),
      .o_addr_hi (addr_hi)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   // Counting first, then software writes override the same cycle
   always_comb begin
      logic [16:0] w;
      logic [5:0]  base;
      w          = 17'h0_0000;
      base       = 6'h00;
      state_next = state_reg;
      tick       = 3'h0;
      sw_touch   = 3'h0;
      for (int t = 0; t < cpu_timer_pkg::TIMER_COUNT; t++) begin
         base = 6'(t) * cpu_timer_pkg::TIMER_STRIDE;
         tick[t] = !state_reg.tmr[t].stop && (state_reg.tmr[t].psc_cnt == 16'h0000);
         state_next.tmr[t].irq = 1'b0;
         if (tick[t]) begin
            // Prescaler restarts each interval, so every period is equal
            state_next.tmr[t].psc_cnt = psc_start(state_reg.tmr[t].psc_set);
            if (state_reg.tmr[t].count == 32'h0000_0000) begin
               state_next.tmr[t].count = state_reg.tmr[t].period;
            end else begin
               state_next.tmr[t].count = state_reg.tmr[t].count - 32'h0000_0001;
            end
            // One pulse per arrival at zero
            state_next.tmr[t].irq = (state_next.tmr[t].count == 32'h0000_0000);
         end else if (!state_reg.tmr[t].stop) begin
            state_next.tmr[t].psc_cnt = state_reg.tmr[t].psc_cnt - 16'h0001;
         end
         // Writes land directly; the frame has no unlock gate
         w = word_wr(base + 6'(cpu_timer_pkg::OFS_CNT_LO), wen_lo, addr_lo, wen_hi, addr_hi,
                     i_mem_wdata);
         if (w[16]) begin
            state_next.tmr[t].count[15:0] = w[15:0];
         end
         sw_touch[t] = sw_touch[t] | w[16];
         w = word_wr(base + 6'(cpu_timer_pkg::OFS_CNT_HI), wen_lo, addr_lo, wen_hi, addr_hi,
                     i_mem_wdata);
         if (w[16]) begin
            state_next.tmr[t].count[31:16] = w[15:0];
         end
         sw_touch[t] = sw_touch[t] | w[16];
         w = word_wr(base + 6'(cpu_timer_pkg::OFS_PRD_LO), wen_lo, addr_lo, wen_hi, addr_hi,
                     i_mem_wdata);
         if (w[16]) begin
            state_next.tmr[t].period[15:0] = w[15:0];
         end
         sw_touch[t] = sw_touch[t] | w[16];
         w = word_wr(base + 6'(cpu_timer_pkg::OFS_PRD_HI), wen_lo, addr_lo, wen_hi, addr_hi,
                     i_mem_wdata);
         if (w[16]) begin
            state_next.tmr[t].period[31:16] = w[15:0];
         end
         sw_touch[t] = sw_touch[t] | w[16];
         w = word_wr(base + 6'(cpu_timer_pkg::OFS_PSC), wen_lo, addr_lo, wen_hi, addr_hi,
                     i_mem_wdata);
         if (w[16]) begin
            state_next.tmr[t].psc_set = w[15:0];
         end
         sw_touch[t] = sw_touch[t] | w[16];
         w = word_wr(base + 6'(cpu_timer_pkg::OFS_CTL), wen_lo, addr_lo, wen_hi, addr_hi,
                     i_mem_wdata);
         if (w[16]) begin
            state_next.tmr[t].stop = w[cpu_timer_pkg::CTL_STOP_BIT];
            // Reload strobe restarts both counter and prescaler cleanly
            if (w[cpu_timer_pkg::CTL_RELOAD_BIT]) begin
               state_next.tmr[t].count   = state_next.tmr[t].period;
               state_next.tmr[t].psc_cnt = psc_start(state_next.tmr[t].psc_set);
            end
         end
         sw_touch[t] = sw_touch[t] | w[16];
      end
      // Read answer one cycle after the strobe, 16 or 32 bits wide
      state_next.rvalid = i_mem_sel && i_mem_rd;
      if (i_mem_sel && i_mem_rd) begin
         if (i_mem_wide) begin
            state_next.rdata = {rd_word(state_reg.tmr, addr_hi),
                                rd_word(state_reg.tmr, addr_lo)};
         end else begin
            state_next.rdata = {16'h0000, rd_word(state_reg.tmr, addr_lo)};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   // Timers start running at divide-by-one with full-scale period
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         for (int t = 0; t < cpu_timer_pkg::TIMER_COUNT; t++) begin
            state_reg.tmr[t].count   <= cpu_timer_pkg::RST_COUNT;
            state_reg.tmr[t].period  <= cpu_timer_pkg::RST_PERIOD;
            state_reg.tmr[t].psc_set <= cpu_timer_pkg::RST_PSC;
            state_reg.tmr[t].psc_cnt <= 16'h0000;
            state_reg.tmr[t].stop    <= cpu_timer_pkg::RST_STOP;
            state_reg.tmr[t].irq     <= 1'b0;
         end
         state_reg.rdata  <= 32'h0000_0000;
         state_reg.rvalid <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs and interrupt routing

   // Line thirteen is shared, so the other source is merged here
   always_comb begin
      o_mem_rdata             = state_reg.rdata;
      o_mem_rvalid            = state_reg.rvalid;
      o_expander_timer0_irq   = state_reg.tmr[0].irq;
      o_cpu_irq_line_thirteen = (state_reg.tmr[1].irq && i_line13_route_en)
                                || i_line13_other_src;
      o_cpu_irq_line_fourteen = state_reg.tmr[2].irq;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   a_irq_single_pulse: assert property (@(posedge i_mclk) disable iff (i_rst)
      (state_reg.tmr[0].irq && state_reg.tmr[0].period != 32'h0000_0000)
      |=> !state_reg.tmr[0].irq)
      else $error("timer 0 interrupt held longer than one cycle");

   a_irq_at_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
      (tick[0] && state_reg.tmr[0].count == 32'h0000_0001 && !sw_touch[0])
      |=> (state_reg.tmr[0].irq && state_reg.tmr[0].count == 32'h0000_0000))
      else $error("timer 0 reached zero without an interrupt");

   a_reload_period: assert property (@(posedge i_mclk) disable iff (i_rst)
      (tick[0] && state_reg.tmr[0].count == 32'h0000_0000 && !sw_touch[0])
      |=> state_reg.tmr[0].count == $past(state_reg.tmr[0].period))
      else $error("timer 0 did not reload its period");

   a_decrement_step: assert property (@(posedge i_mclk) disable iff (i_rst)
      (tick[1] && state_reg.tmr[1].count != 32'h0000_0000 && !sw_touch[1])
      |=> state_reg.tmr[1].count == $past(state_reg.tmr[1].count) - 32'h0000_0001)
      else $error("timer 1 did not step down by one");

   a_hold_between: assert property (@(posedge i_mclk) disable iff (i_rst)
      (!tick[2] && !sw_touch[2]) |=> $stable(state_reg.tmr[2].count))
      else $error("timer 2 counted between prescale intervals");

   a_psc_interval: assert property (@(posedge i_mclk) disable iff (i_rst)
      (tick[0] && state_reg.tmr[0].psc_set == 16'h0003 && !sw_touch[0]) ##1 !sw_touch[0]
      ##1 !sw_touch[0] |-> (!tick[0] && !$past(tick[0])) ##1 tick[0])
      else $error("timer 0 prescale interval not three cycles");

   a_psc_restart: assert property (@(posedge i_mclk) disable iff (i_rst)
      (tick[1] && state_reg.tmr[1].count == 32'h0000_0000 && !sw_touch[1])
      |=> state_reg.tmr[1].psc_cnt == psc_start(state_reg.tmr[1].psc_set))
      else $error("timer 1 prescaler not restarted at reload");

   a_line14_route: assert property (@(posedge i_mclk) disable iff (i_rst)
      $rose(state_reg.tmr[2].irq) |-> o_cpu_irq_line_fourteen)
      else $error("line fourteen missed timer 2 interrupt");

   a_line13_route: assert property (@(posedge i_mclk) disable iff (i_rst)
      (state_reg.tmr[1].irq && i_line13_route_en) |-> o_cpu_irq_line_thirteen)
      else $error("line thirteen missed timer 1 interrupt");

   a_expander_route: assert property (@(posedge i_mclk) disable iff (i_rst)
      o_expander_timer0_irq == state_reg.tmr[0].irq && (o_cpu_irq_line_fourteen
      == state_reg.tmr[2].irq))
      else $error("timer 0 interrupt misrouted");

   a_read_answer: assert property (@(posedge i_mclk) disable iff (i_rst)
      (i_mem_sel && i_mem_rd && !i_mem_wide && i_mem_addr == 6'h06)
      |=> (o_mem_rvalid && o_mem_rdata == {16'h0000, $past(state_reg.tmr[0].psc_set)}))
      else $error("16-bit read answer wrong");

   a_write_direct: assert property (@(posedge i_mclk) disable iff (i_rst)
      (i_mem_sel && i_mem_wr && i_mem_wide && i_mem_addr == 6'h0A)
      |=> state_reg.tmr[1].period == $past(i_mem_wdata))
      else $error("32-bit period write did not take effect");

endmodule

`default_nettype wire

//--- irq_sink.sv
// Far-side model: the CPU core and the interrupt expander, seen as sinks.
// Assumes interrupt lines are sampled on i_mclk; bit 0 expander, 1 line 13, 2 line 14.
`timescale 1ns/1ps
`default_nettype none

module irq_sink (
   input  wire logic        i_mclk,    // Core clock
   input  wire logic        i_rst,     // Synchronous reset, high
   input  wire logic [2:0]  i_irq,     // Expander input, line 13, line 14
   output logic      [47:0] o_gaps,    // Cycles between the last two pulses, per line
   output logic      [23:0] o_counts,  // Pulses seen per line
   output logic      [2:0]  o_long     // A line stayed high on two samples
);
   logic [47:0] run_reg;   // Cycles since the last pulse, per line
   logic [2:0]  prev_reg;  // Line levels one sample back

   ////////////////////////////////////////////////////////////////////////////
   // A pulse counts once, at its first high sample, so a stuck line cannot
   // inflate the count; it is flagged on o_long instead
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         run_reg  <= '0;
         prev_reg <= '0;
         o_gaps   <= '0;
         o_counts <= '0;
         o_long   <= '0;
      end else begin
         prev_reg <= i_irq;
         for (int i = 0; i < 3; i++) begin
            run_reg[16*i +: 16] <= run_reg[16*i +: 16] + 16'h0001;
            // Rising sample: one interrupt per arrival at zero
            if (i_irq[i] && !prev_reg[i]) begin
               o_gaps[16*i +: 16]  <= run_reg[16*i +: 16];
               run_reg[16*i +: 16] <= 16'h0001;
               o_counts[8*i +: 8]  <= o_counts[8*i +: 8] + 8'h01;
            end
            // Second high sample in a row: not a single pulse
            if (i_irq[i] && prev_reg[i]) begin
               o_long[i] <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the three countdown timers and their interrupt lines.
// Assumes the design's bus takes a request at one edge and answers a read one cycle later.
`timescale 1ns/1ps
`default_nettype none

module tb;
   typedef struct {
      string       nm;
      logic [31:0] v;
   } note_t;

   logic        i_mclk, i_rst, sel, rd, wr, wide, r13, o13src;  // Bench-driven inputs
   logic [5:0]  addr;      // Word address
   logic [31:0] wdata;     // Write data
   logic [31:0] rdata;     // Read data seen
   logic        rvalid, irq0, irq13, irq14;  // Design outputs
   logic [47:0] gaps;      // Pulse spacing per line
   logic [23:0] counts;    // Pulse counts per line
   logic [2:0]  longs;     // Over-long pulse flags
   note_t       notes [$]; // Expected read results, oldest first
   int          bad_count, checks_done, cycles;
   int unsigned n, p;      // Random period and prescale
   logic [7:0]  c0;        // Saved pulse count

   cpu_countdown_timers DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_mem_sel(sel), .i_mem_rd(rd),
      .i_mem_wr(wr), .i_mem_wide(wide), .i_mem_addr(addr), .i_mem_wdata(wdata),
      .i_line13_route_en(r13), .i_line13_other_src(o13src), .o_mem_rdata(rdata),
      .o_mem_rvalid(rvalid), .o_expander_timer0_irq(irq0), .o_cpu_irq_line_thirteen(irq13),
      .o_cpu_irq_line_fourteen(irq14));
   irq_sink far_end (.i_mclk(i_mclk), .i_rst(i_rst), .i_irq({irq14, irq13, irq0}),
      .o_gaps(gaps), .o_counts(counts), .o_long(longs));

   ////////////////////////////////////////////////////////////////////////////
   // Comparison, verdict and bus tasks
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic final_report();
      if (bad_count == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // One request, raised just after an edge and held through the taking edge
   task automatic access(input logic w, input logic wd, input logic [5:0] a,
                         input logic [31:0] d);
      @(posedge i_mclk);
      #1;
      sel = 1'b1; rd = !w; wr = w; wide = wd; addr = a; wdata = d;
      @(posedge i_mclk);
      #1;
      sel = 1'b0; rd = 1'b0; wr = 1'b0;
   endtask

   // Read with its expected value noted first
   task automatic rd_exp(input string nm, input logic wd, input logic [5:0] a,
                         input logic [31:0] e);
      notes.push_back('{nm, e});
      access(1'b0, wd, a, 32'h0000_0000);
   endtask

   // Bounded wait for k more pulses on one line
   task automatic wait_pulses(input int ln, input int k);
      int st, t;
      st = counts[8*ln +: 8];
      for (t = 0; t < 2000 && counts[8*ln +: 8] != 8'(st + k); t++) @(posedge i_mclk);
      if (t == 2000) check("pulse wait", 32'h0000_0000, 32'h0000_0001);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Clock, hang guard and read-result watcher
   initial begin
      i_mclk = 1'b0;
      forever #2.5 i_mclk = ~i_mclk;
   end

   // Cuts a hang short; ceiling is ample for the planned traffic
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         final_report();
      end
   end

   // Sampling on the falling edge keeps clear of the launching edge
   always @(negedge i_mclk) begin
      if (rvalid === 1'b1) begin
         if (notes.size() == 0) begin
            check("stray read valid", 32'h0000_0001, 32'h0000_0000);
         end else begin
            check(notes[0].nm, rdata, notes[0].v);
            void'(notes.pop_front());
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'hAE9B));
      i_rst = 1'b1; sel = 1'b0; rd = 1'b0; wr = 1'b0; wide = 1'b0;
      addr = 6'h00; wdata = 32'h0000_0000; r13 = 1'b1; o13src = 1'b0;
      repeat (4) @(posedge i_mclk);
      #1;
      i_rst = 1'b0;
      // Reset values in both widths, every timer
      for (int t = 0; t < 3; t++) begin
         rd_exp("period lo", 1'b0, 6'(8*t+2), 32'h0000_FFFF);
         rd_exp("period wide", 1'b1, 6'(8*t+2), 32'hFFFF_FFFF);
         rd_exp("prescale", 1'b0, 6'(8*t+6), 32'h0000_0001);
      end
      // Unmapped words read zero and ignore writes; no unlock step used
      access(1'b1, 1'b0, 6'h18, 32'h0000_ABCD);
      rd_exp("unmapped", 1'b0, 6'h18, 32'h0000_0000);
      rd_exp("slot gap", 1'b0, 6'h05, 32'h0000_0000);
      // Stopped timer keeps a preset count; halves pair into one wide value
      access(1'b1, 1'b0, 6'h04, 32'h0000_0001);
      access(1'b1, 1'b1, 6'h00, 32'h1234_5678);
      repeat (20) @(posedge i_mclk);
      rd_exp("held count", 1'b1, 6'h00, 32'h1234_5678);
      access(1'b1, 1'b0, 6'h02, 32'h0000_9ABC);
      access(1'b1, 1'b0, 6'h03, 32'h0000_DEF0);
      rd_exp("paired period", 1'b1, 6'h02, 32'hDEF0_9ABC);
      // Random short period and prescale; steady spacing of zero arrivals
      for (int t = 0; t < 3; t++) begin
         n = 2 + $urandom % 4;
         // Timer 0 runs at divide-by-three so the interval check is exercised
         p = (t == 0) ? 3 : 2 + $urandom % 3;
         access(1'b1, 1'b1, 6'(8*t+2), n);
         access(1'b1, 1'b0, 6'(8*t+6), p);
         access(1'b1, 1'b0, 6'(8*t+4), 32'h0000_0002);
         wait_pulses(t, 3);
         check("zero spacing", gaps[16*t +: 16], (n + 1) * p);
         check("line pulses", counts[8*t +: 8] >= 8'h03, 1'b1);
      end
      // Line 13 disconnected from timer 1, then the other source alone
      #1;
      r13 = 1'b0;
      c0 = counts[15:8];
      repeat (60) @(posedge i_mclk);
      #1;
      check("masked line 13", counts[15:8], c0);
      o13src = 1'b1;
      #1;
      check("shared line 13", irq13, 1'b1);
      @(posedge i_mclk);
      #1;
      o13src = 1'b0;
      @(posedge i_mclk);
      #1;
      r13 = 1'b1;
      for (int k = 0; k < 20 && notes.size() != 0; k++) @(posedge i_mclk);
      check("pending reads", notes.size(), 32'h0000_0000);
      check("long pulse", longs, 32'h0000_0000);
      final_report();
   end
endmodule
`default_nettype wire
